// File: cit_cycle_timer.sv
// cit_cycle_timer.sv: instruction cycle-count sequencer of the processor core
// assumes: inputs synchronous to clk; start only honoured while ready is high
`timescale 1ns/1ns
`include "cit_timing_regs.svh"

// Contract
// - each cost is total clocks plus bus read and write counts, fetches included
// - ops marked as needing it add effective-address clocks, reads and writes
// - indexed modes cost the same for word or long index register
// - multi-register move count n is registers moved; totals scale linearly
// - word multi-register load from memory: 12+4n clocks, 3+n reads, 0 writes
// - long multi-register load, register indirect: 12+8n clocks, 3+2n reads
// - multi-register store: 8+4n, 2 reads, n writes; long 8+8n, 2n writes
// - multiprecision cost covers operand fetches, operation, store and prefetch
// - extended add/subtract: 4 (1/0) reg, 18 (3/1) mem, 30 (5/2) long mem
// - decimal add/subtract: 6 (1/0) register, 18 (3/1) memory to memory
// - external-reset instruction: 132 clocks, one read, no writes
// - bounds trap 40, divide by zero 38, (4/3)+EA; no trap 10+EA
// - exceptions include stacking, vector and first fetch; address/bus error 50 (4/7)
// - interrupt exception 44 clocks, 5 reads, 3 writes, four-clock acknowledge
// - after reset and halt negated: 40 clocks, 6 reads, then execution
// - illegal instruction exception: 34 clocks, 4 reads, 3 writes
// - privilege, trace, software trap 34 (4/3); overflow trap 34 (5/3)
module cit_cycle_timer
	import cit_timing_pkg::*;
#(
	parameter int N_W  = 5,
	parameter int EA_W = 8,
	parameter int WS_W = 4
) (
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic                  halt_b,
	input  wire logic                  start,
	input  wire cit_op_t               op,
	input  wire logic [N_W-1:0]        reg_count,
	input  wire logic [EA_W-1:0]       ea_clocks,
	input  wire logic [3:0]            ea_reads,
	input  wire logic [3:0]            ea_writes,
	input  wire logic [WS_W-1:0]       wait_states,
	output logic                       ready,
	output logic                       busy,
	output logic                       done,
	output logic [`CIT_CNT_W-1:0]      total_clocks,
	output logic [`CIT_CNT_W-1:0]      read_cycles,
	output logic [`CIT_CNT_W-1:0]      write_cycles
);
	localparam int CW = `CIT_CNT_W;

	// ****************************************
	// state record
	// ****************************************
	cit_regs_t q_r;
	cit_regs_t q_nxt;

	localparam cit_regs_t RESET_Q = '{st: CIT_ST_WAIT_HALT, busy: 1'b0, done: 1'b0,
		ready: 1'b0, remain: `CIT_ZERO, total: `CIT_ZERO, rd: `CIT_ZERO, wr: `CIT_ZERO};

	logic          accept;
	logic [CW-1:0] base_clk;
	logic [CW-1:0] base_rd;
	logic [CW-1:0] base_wr;
	logic [CW-1:0] clk_per_n;
	logic [CW-1:0] bus_per_n;
	logic          n_is_rd;
	logic          add_ea;
	logic [CW-1:0] n_ext;
	logic [CW-1:0] sum_rd;
	logic [CW-1:0] sum_wr;
	logic [CW-1:0] sum_clk;

	assign accept = start && q_r.ready;
	assign n_ext  = CW'(reg_count);

	// ****************************************
	// base cost table
	// ****************************************
	// every figure holds the opcode fetch and operand traffic, except the address part that add_ea adds later
	always_comb begin
		base_clk  = `CIT_ZERO;
		base_rd   = `CIT_ZERO;
		base_wr   = `CIT_ZERO;
		clk_per_n = `CIT_ZERO;
		bus_per_n = `CIT_ZERO;
		n_is_rd   = 1'b1;
		add_ea    = 1'b0;
		unique case (op)
			CIT_OP_MRM_LOAD_W: begin
				base_clk  = `CIT_MRM_LOAD_CLK;
				base_rd   = `CIT_MRM_LOAD_RD;
				clk_per_n = `CIT_CLK_PER_WORD;
				bus_per_n = `CIT_BUS_PER_WORD;
			end
			CIT_OP_MRM_LOAD_L: begin
				base_clk  = `CIT_MRM_LOAD_CLK;
				base_rd   = `CIT_MRM_LOAD_RD;
				clk_per_n = `CIT_CLK_PER_LONG;
				bus_per_n = `CIT_BUS_PER_LONG;
			end
			CIT_OP_MRM_STORE_W, CIT_OP_MRM_STORE_L: begin
				base_clk  = `CIT_MRM_STORE_CLK;
				base_rd   = `CIT_MRM_STORE_RD;
				n_is_rd   = 1'b0;
				clk_per_n = (op == CIT_OP_MRM_STORE_W) ? `CIT_CLK_PER_WORD : `CIT_CLK_PER_LONG;
				bus_per_n = (op == CIT_OP_MRM_STORE_W) ? `CIT_BUS_PER_WORD : `CIT_BUS_PER_LONG;
			end
			// one code per indexed form: index width never changes the cost
			CIT_OP_JUMP_IND: begin
				base_clk = `CIT_JMP_IND_CLK;
				base_rd  = `CIT_JMP_IND_RD;
			end
			CIT_OP_JUMP_IDX: begin
				base_clk = `CIT_JMP_IDX_CLK;
				base_rd  = `CIT_JMP_IDX_RD;
			end
			CIT_OP_CALL_IND, CIT_OP_CALL_IDX: begin
				base_clk = (op == CIT_OP_CALL_IND) ? `CIT_CALL_IND_CLK : `CIT_CALL_IDX_CLK;
				base_rd  = `CIT_CALL_RD;
				base_wr  = `CIT_CALL_WR;
			end
			CIT_OP_LEA_IND: begin
				base_clk = `CIT_LEA_IND_CLK;
				base_rd  = `CIT_LEA_IND_RD;
			end
			CIT_OP_LEA_IDX: begin
				base_clk = `CIT_LEA_IDX_CLK;
				base_rd  = `CIT_LEA_IDX_RD;
			end
			CIT_OP_PEA_IND, CIT_OP_PEA_IDX: begin
				base_clk = (op == CIT_OP_PEA_IND) ? `CIT_PEA_IND_CLK : `CIT_PEA_IDX_CLK;
				base_rd  = (op == CIT_OP_PEA_IND) ? `CIT_PEA_IND_RD : `CIT_PEA_IDX_RD;
				base_wr  = `CIT_PEA_WR;
			end
			// both operands, the operation, the store and the prefetch
			CIT_OP_XARITH_REG: begin
				base_clk = `CIT_XARITH_REG_CLK;
				base_rd  = `CIT_MP_REG_RD;
			end
			CIT_OP_XARITH_REG_L: begin
				base_clk = `CIT_XARITH_REGL_CLK;
				base_rd  = `CIT_MP_REG_RD;
			end
			CIT_OP_XARITH_MEM: begin
				base_clk = `CIT_XARITH_MEM_CLK;
				base_rd  = `CIT_MP_MEM_RD;
				base_wr  = `CIT_MP_MEM_WR;
			end
			CIT_OP_XARITH_MEM_L: begin
				base_clk = `CIT_XARITH_MEML_CLK;
				base_rd  = `CIT_MP_MEML_RD;
				base_wr  = `CIT_MP_MEML_WR;
			end
			CIT_OP_DEC_REG: begin
				base_clk = `CIT_DEC_REG_CLK;
				base_rd  = `CIT_MP_REG_RD;
			end
			CIT_OP_DEC_MEM: begin
				base_clk = `CIT_DEC_MEM_CLK;
				base_rd  = `CIT_MP_MEM_RD;
				base_wr  = `CIT_MP_MEM_WR;
			end
			CIT_OP_EXT_RESET: begin
				base_clk = `CIT_EXT_RESET_CLK;
				base_rd  = `CIT_EXT_RESET_RD;
			end
			CIT_OP_CHK_PASS: begin
				base_clk = `CIT_CHK_PASS_CLK;
				base_rd  = `CIT_CHK_PASS_RD;
				add_ea   = 1'b1;
			end
			CIT_OP_CHK_TRAP, CIT_OP_DIV_ZERO: begin
				base_clk = (op == CIT_OP_CHK_TRAP) ? `CIT_CHK_TRAP_CLK : `CIT_DIVZ_CLK;
				base_rd  = `CIT_EXC_RD;
				base_wr  = `CIT_EXC_WR;
				add_ea   = 1'b1;
			end
			// exception figures run through stacking, vector and first fetch
			CIT_OP_ADDR_ERR, CIT_OP_BUS_ERR: begin
				base_clk = `CIT_BUSERR_CLK;
				base_rd  = `CIT_EXC_RD;
				base_wr  = `CIT_BUSERR_WR;
			end
			CIT_OP_INTERRUPT: begin
				// acknowledge taken as one plain bus read of four clocks
				base_clk = `CIT_IRQ_CLK;
				base_rd  = `CIT_IRQ_RD;
				base_wr  = `CIT_EXC_WR;
			end
			CIT_OP_ILLEGAL, CIT_OP_PRIV_VIOL, CIT_OP_TRACE, CIT_OP_SW_TRAP: begin
				base_clk = `CIT_TRAP34_CLK;
				base_rd  = `CIT_EXC_RD;
				base_wr  = `CIT_EXC_WR;
			end
			CIT_OP_OVF_TRAP: begin
				base_clk = `CIT_TRAP34_CLK;
				base_rd  = `CIT_OVF_RD;
				base_wr  = `CIT_EXC_WR;
			end
			default: begin
				base_clk = `CIT_ZERO; // undefined codes cost nothing and still finish
			end
		endcase
	end

	// ****************************************
	// totals: base, n scaling, address part, wait states
	// ****************************************
	// n only scales; no fixed part depends on it
	always_comb begin
		sum_rd  = base_rd + (n_is_rd ? CW'(bus_per_n * n_ext) : `CIT_ZERO);
		sum_wr  = base_wr + (n_is_rd ? `CIT_ZERO : CW'(bus_per_n * n_ext));
		sum_clk = base_clk + CW'(clk_per_n * n_ext);
		if (add_ea) begin
			sum_rd  = sum_rd + CW'(ea_reads);
			sum_wr  = sum_wr + CW'(ea_writes);
			sum_clk = sum_clk + CW'(ea_clocks);
		end
		// figures assume four-clock bus cycles; waits stretch every one
		sum_clk = sum_clk + CW'(CW'(wait_states) * (sum_rd + sum_wr));
	end

	// ****************************************
	// sequencer
	// ****************************************
	// a zero-cost code still runs one cycle so done always pulses
	always_comb begin
		q_nxt      = q_r;
		q_nxt.done = 1'b0;
		unique case (q_r.st)
			CIT_ST_WAIT_HALT: begin
				if (halt_b) begin
					q_nxt.st     = CIT_ST_RUN;
					q_nxt.busy   = 1'b1;
					q_nxt.rd     = `CIT_RST_SEQ_RD;
					q_nxt.wr     = `CIT_ZERO;
					q_nxt.total  = `CIT_RST_SEQ_CLK + CW'(CW'(wait_states) * `CIT_RST_SEQ_RD);
					q_nxt.remain = q_nxt.total;
				end
			end
			CIT_ST_IDLE: begin
				if (accept) begin
					q_nxt.st     = CIT_ST_RUN;
					q_nxt.busy   = 1'b1;
					q_nxt.ready  = 1'b0;
					q_nxt.rd     = sum_rd;
					q_nxt.wr     = sum_wr;
					q_nxt.total  = sum_clk;
					q_nxt.remain = (sum_clk == `CIT_ZERO) ? 12'h001 : sum_clk;
				end
			end
			CIT_ST_RUN: begin
				q_nxt.remain = q_r.remain - 12'h001;
				if (q_r.remain == 12'h001) begin
					q_nxt.st    = CIT_ST_IDLE;
					q_nxt.busy  = 1'b0;
					q_nxt.done  = 1'b1;
					q_nxt.ready = 1'b1;
				end
			end
			default: begin
				q_nxt = RESET_Q;
			end
		endcase
	end

	// synchronous reset; the reset sequence starts only after release
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q_r <= RESET_Q;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign ready        = q_r.ready;
	assign busy         = q_r.busy;
	assign done         = q_r.done;
	assign total_clocks = q_r.total;
	assign read_cycles  = q_r.rd;
	assign write_cycles = q_r.wr;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_take(cit_op_t o);
		accept && op == o;
	endsequence

	sequence s_last;
		busy && q_r.remain == 12'h001;
	endsequence

	load_word_a: assert property (s_take(CIT_OP_MRM_LOAD_W) |=>
		read_cycles == 12'h003 + CW'($past(reg_count)) && write_cycles == `CIT_ZERO)
		else $error("word load read count wrong");
	load_long_a: assert property (s_take(CIT_OP_MRM_LOAD_L) ##0 wait_states == '0 |=>
		total_clocks == 12'h00c + CW'(12'h008 * CW'($past(reg_count))))
		else $error("long load clock count wrong");
	store_long_a: assert property (s_take(CIT_OP_MRM_STORE_L) |=>
		write_cycles == CW'(12'h002 * CW'($past(reg_count))) && read_cycles == 12'h002)
		else $error("long store bus counts wrong");
	ext_reset_a: assert property (s_take(CIT_OP_EXT_RESET) |=>
		total_clocks == 12'h084 + CW'($past(wait_states)) && read_cycles == 12'h001)
		else $error("reset instruction cost wrong");
	divzero_ea_a: assert property (s_take(CIT_OP_DIV_ZERO) |=>
		read_cycles == 12'h004 + CW'($past(ea_reads)))
		else $error("address reads not added");
	illegal_wait_a: assert property (s_take(CIT_OP_ILLEGAL) |=>
		total_clocks == 12'h022 + CW'(CW'($past(wait_states)) * 12'h007))
		else $error("wait states not scaled");
	irq_cost_a: assert property (s_take(CIT_OP_INTERRUPT) ##0 wait_states == '0 |=>
		total_clocks == 12'h02c && read_cycles == 12'h005 && write_cycles == 12'h003)
		else $error("interrupt cost wrong");
	reset_seq_a: assert property (q_r.st == CIT_ST_WAIT_HALT && halt_b |=>
		(busy && read_cycles == 12'h006 && !ready) [*2])
		else $error("reset sequence not started");
	finish_a: assert property (s_last |=> done && !busy ##1 !done)
		else $error("done pulse wrong");
	bus_err_a: assert property (s_take(CIT_OP_BUS_ERR) |=> write_cycles == 12'h007)
		else $error("bus error writes wrong");
endmodule

// File: cit_cycle_timer_bench.sv
// cit_cycle_timer_bench.sv: self-checking bench of the instruction cycle timer
// assumes: cit_timing_pkg compiled first; memory model supplies the wait states
`timescale 1ns/1ns

module cit_cycle_timer_bench
	import cit_timing_pkg::*;
;
	typedef struct {
		cit_op_t     op;
		logic [4:0]  n;
		logic        slow;
		logic [11:0] tot;
		logic [11:0] rd;
		logic [11:0] wr;
	} cit_row_t;

	localparam logic [3:0] SLOW_WS = 4'h3;
	localparam logic [7:0] EA_CLK  = 8'h0a;
	localparam logic [3:0] EA_RD   = 4'h2;
	localparam logic [3:0] EA_WR   = 4'h1;

	logic        clk, rst_b, halt_b, start, slow, ready, busy, done, plus;
	cit_op_t     op;
	logic [4:0]  reg_count;
	logic [3:0]  ws;
	logic [11:0] total_clocks, read_cycles, write_cycles, e_tot, e_rd, e_wr;
	int          err_total, cmp_count, bc;
	cit_row_t    rows [32];

	cit_mem_model #(.WS_SLOW(SLOW_WS)) mem (
		.slow        (slow),
		.wait_states (ws)
	);

	cit_cycle_timer DUT (
		.clk          (clk),
		.rst_b        (rst_b),
		.halt_b       (halt_b),
		.start        (start),
		.op           (op),
		.reg_count    (reg_count),
		.ea_clocks    (EA_CLK),
		.ea_reads     (EA_RD),
		.ea_writes    (EA_WR),
		.wait_states  (ws),
		.ready        (ready),
		.busy         (busy),
		.done         (done),
		.total_clocks (total_clocks),
		.read_cycles  (read_cycles),
		.write_cycles (write_cycles)
	);

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// counts busy cycles; bounded so a stuck busy cannot hang the run
	task automatic wait_done(output int n_busy);
		int k;
		k = 0;
		n_busy = 0;
		while (busy !== 1'b1 && k < 10) begin
			@(posedge clk);
			#1;
			k++;
		end
		while (busy === 1'b1 && n_busy < 5000) begin
			@(posedge clk);
			#1;
			n_busy++;
		end
		chk({11'h000, done}, 12'h001);
		chk({11'h000, ready}, 12'h001);
	endtask

	task automatic do_job(input cit_op_t o, input logic [4:0] n, input logic s, output int nb);
		int k;
		k = 0;
		while (ready !== 1'b1 && k < 2000) begin
			@(posedge clk);
			#1;
			k++;
		end
		start     = 1'b1;
		op        = o;
		reg_count = n;
		slow      = s;
		@(posedge clk);
		#1;
		start = 1'b0;
		wait_done(nb);
	endtask

	// ****************************************
	// clock and watchdog
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// whole run is under two thousand cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		$display("watchdog expired");
		report_and_stop();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rows = '{
			'{CIT_OP_MRM_LOAD_W, 5'h05, 1'b0, 12'h20, 12'h8, 12'h0},
			'{CIT_OP_MRM_LOAD_L, 5'h03, 1'b1, 12'h24, 12'h9, 12'h0},
			'{CIT_OP_MRM_LOAD_L, 5'h1f, 1'b0, 12'h104, 12'h41, 12'h0},
			'{CIT_OP_MRM_STORE_W, 5'h07, 1'b0, 12'h24, 12'h2, 12'h7},
			'{CIT_OP_MRM_STORE_W, 5'h00, 1'b0, 12'h08, 12'h2, 12'h0},
			'{CIT_OP_MRM_STORE_L, 5'h10, 1'b1, 12'h88, 12'h2, 12'h20},
			'{CIT_OP_JUMP_IND, 5'h1f, 1'b0, 12'h08, 12'h2, 12'h0},
			'{CIT_OP_JUMP_IDX, 5'h00, 1'b0, 12'h0e, 12'h3, 12'h0},
			'{CIT_OP_CALL_IND, 5'h00, 1'b1, 12'h10, 12'h2, 12'h2},
			'{CIT_OP_CALL_IDX, 5'h00, 1'b0, 12'h16, 12'h2, 12'h2},
			'{CIT_OP_LEA_IND, 5'h00, 1'b0, 12'h04, 12'h1, 12'h0},
			'{CIT_OP_LEA_IDX, 5'h00, 1'b0, 12'h0c, 12'h2, 12'h0},
			'{CIT_OP_PEA_IND, 5'h00, 1'b0, 12'h0c, 12'h1, 12'h2},
			'{CIT_OP_PEA_IDX, 5'h00, 1'b1, 12'h14, 12'h2, 12'h2},
			'{CIT_OP_XARITH_REG, 5'h00, 1'b0, 12'h04, 12'h1, 12'h0},
			'{CIT_OP_XARITH_REG_L, 5'h00, 1'b0, 12'h08, 12'h1, 12'h0},
			'{CIT_OP_XARITH_MEM, 5'h00, 1'b0, 12'h12, 12'h3, 12'h1},
			'{CIT_OP_XARITH_MEM_L, 5'h00, 1'b1, 12'h1e, 12'h5, 12'h2},
			'{CIT_OP_DEC_REG, 5'h00, 1'b0, 12'h06, 12'h1, 12'h0},
			'{CIT_OP_DEC_MEM, 5'h00, 1'b0, 12'h12, 12'h3, 12'h1},
			'{CIT_OP_CHK_PASS, 5'h00, 1'b1, 12'h0a, 12'h1, 12'h0},
			'{CIT_OP_CHK_TRAP, 5'h00, 1'b0, 12'h28, 12'h4, 12'h3},
			'{CIT_OP_DIV_ZERO, 5'h00, 1'b0, 12'h26, 12'h4, 12'h3},
			'{CIT_OP_ADDR_ERR, 5'h00, 1'b0, 12'h32, 12'h4, 12'h7},
			'{CIT_OP_BUS_ERR, 5'h00, 1'b1, 12'h32, 12'h4, 12'h7},
			'{CIT_OP_INTERRUPT, 5'h00, 1'b1, 12'h2c, 12'h5, 12'h3},
			'{CIT_OP_ILLEGAL, 5'h00, 1'b0, 12'h22, 12'h4, 12'h3},
			'{CIT_OP_PRIV_VIOL, 5'h00, 1'b0, 12'h22, 12'h4, 12'h3},
			'{CIT_OP_TRACE, 5'h00, 1'b0, 12'h22, 12'h4, 12'h3},
			'{CIT_OP_SW_TRAP, 5'h00, 1'b1, 12'h22, 12'h4, 12'h3},
			'{CIT_OP_OVF_TRAP, 5'h00, 1'b0, 12'h22, 12'h5, 12'h3},
			'{CIT_OP_EXT_RESET, 5'h00, 1'b0, 12'h84, 12'h1, 12'h0}
		};
		err_total = 0;
		cmp_count = 0;
		rst_b     = 1'b0;
		halt_b    = 1'b1;
		start     = 1'b0;
		slow      = 1'b0;
		op        = CIT_OP_JUMP_IND;
		reg_count = 5'h00;
		repeat (2) @(posedge clk);
		#1;
		chk({10'h000, ready, busy}, 12'h000);
		rst_b = 1'b1;
		wait_done(bc);
		chk(12'(bc), 12'h028);
		chk(read_cycles, 12'h006);
		chk(write_cycles, 12'h000);
		$display("reset sequence test done");
		// table rows run back to back: each start lands in the previous done cycle
		foreach (rows[i]) begin
			plus  = rows[i].op inside {CIT_OP_CHK_PASS, CIT_OP_CHK_TRAP, CIT_OP_DIV_ZERO};
			e_rd  = rows[i].rd + (plus ? {8'h00, EA_RD} : 12'h000);
			e_wr  = rows[i].wr + (plus ? {8'h00, EA_WR} : 12'h000);
			e_tot = rows[i].tot + (plus ? {4'h0, EA_CLK} : 12'h000)
				+ (rows[i].slow ? {8'h00, SLOW_WS} : 12'h000) * (e_rd + e_wr);
			do_job(rows[i].op, rows[i].n, rows[i].slow, bc);
			chk(12'(bc), e_tot);
			chk(total_clocks, e_tot);
			chk(read_cycles, e_rd);
			chk(write_cycles, e_wr);
			$display("row %0d done", i);
		end
		// a start while busy must be ignored and leave the running job intact
		start = 1'b1;
		op    = CIT_OP_EXT_RESET;
		slow  = 1'b0;
		@(posedge clk);
		#1;
		start = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		start = 1'b1;
		op    = CIT_OP_ILLEGAL;
		slow  = 1'b1;
		@(posedge clk);
		#1;
		start = 1'b0;
		wait_done(bc);
		chk(12'(bc + 4), 12'h084);
		chk(read_cycles, 12'h001);
		chk(write_cycles, 12'h000);
		@(posedge clk);
		#1;
		chk({11'h000, done}, 12'h000);
		$display("refused start test done");
		// second reset in mid-job; sequence waits for halt to be negated
		start = 1'b1;
		op    = CIT_OP_ILLEGAL;
		@(posedge clk);
		#1;
		start = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		rst_b  = 1'b0;
		halt_b = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(total_clocks, 12'h000);
		rst_b = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk({10'h000, ready, busy}, 12'h000);
		halt_b = 1'b1;
		wait_done(bc);
		chk(12'(bc), 12'h028 + 12'h006 * {8'h00, SLOW_WS});
		chk(read_cycles, 12'h006);
		chk(write_cycles, 12'h000);
		$display("mid-run reset test done");
		report_and_stop();
	end
endmodule

// File: cit_mem_model.sv
// cit_mem_model.sv: memory and peripheral side of the timer, prompt or slow
// assumes: the timer has no bus pins; only the wait states per bus cycle reach it
`timescale 1ns/1ns

module cit_mem_model #(
	parameter logic [3:0] WS_SLOW = 4'h3
) (
	input  wire logic  slow,
	output logic [3:0] wait_states
);
	// ****************************************
	// answer speed
	// ****************************************
	// slow memory stretches every bus cycle alike, reads and writes the same
	assign wait_states = slow ? WS_SLOW : 4'h0;
endmodule

// File: cit_timing_pkg.sv
// cit_timing_pkg.sv: operation codes, states and the state record of the timer
// assumes: nothing beyond the constants header
package cit_timing_pkg;
	`include "cit_timing_regs.svh"

	// ****************************************
	// operations that can be timed
	// ****************************************
	typedef enum logic [4:0] {
		CIT_OP_MRM_LOAD_W,
		CIT_OP_MRM_LOAD_L,
		CIT_OP_MRM_STORE_W,
		CIT_OP_MRM_STORE_L,
		CIT_OP_JUMP_IND,
		CIT_OP_JUMP_IDX,
		CIT_OP_CALL_IND,
		CIT_OP_CALL_IDX,
		CIT_OP_LEA_IND,
		CIT_OP_LEA_IDX,
		CIT_OP_PEA_IND,
		CIT_OP_PEA_IDX,
		CIT_OP_XARITH_REG,
		CIT_OP_XARITH_REG_L,
		CIT_OP_XARITH_MEM,
		CIT_OP_XARITH_MEM_L,
		CIT_OP_DEC_REG,
		CIT_OP_DEC_MEM,
		CIT_OP_EXT_RESET,
		CIT_OP_CHK_PASS,
		CIT_OP_CHK_TRAP,
		CIT_OP_DIV_ZERO,
		CIT_OP_ADDR_ERR,
		CIT_OP_BUS_ERR,
		CIT_OP_INTERRUPT,
		CIT_OP_ILLEGAL,
		CIT_OP_PRIV_VIOL,
		CIT_OP_TRACE,
		CIT_OP_SW_TRAP,
		CIT_OP_OVF_TRAP
	} cit_op_t;

	typedef enum logic [1:0] {
		CIT_ST_WAIT_HALT,
		CIT_ST_IDLE,
		CIT_ST_RUN
	} cit_state_t;

	// whole state of the timer, one record
	typedef struct packed {
		cit_state_t            st;
		logic                  busy;
		logic                  done;
		logic                  ready;
		logic [`CIT_CNT_W-1:0] remain;
		logic [`CIT_CNT_W-1:0] total;
		logic [`CIT_CNT_W-1:0] rd;
		logic [`CIT_CNT_W-1:0] wr;
	} cit_regs_t;
endpackage

// File: cit_timing_regs.svh
// cit_timing_regs.svh: cycle and bus-cycle figures of the instruction timer
// assumes: included by cit_timing_pkg and cit_cycle_timer, all values 12 bits wide
`ifndef CIT_TIMING_REGS_SVH
`define CIT_TIMING_REGS_SVH

// ****************************************
// widths
// ****************************************
`define CIT_CNT_W           12
`define CIT_ZERO            12'h000

// ****************************************
// per-register scale of multi-register moves
// ****************************************
`define CIT_CLK_PER_WORD    12'h004
`define CIT_CLK_PER_LONG    12'h008
`define CIT_BUS_PER_WORD    12'h001
`define CIT_BUS_PER_LONG    12'h002

// ****************************************
// multi-register move bases: clocks and reads
// ****************************************
`define CIT_MRM_LOAD_CLK    12'h00c
`define CIT_MRM_LOAD_RD     12'h003
`define CIT_MRM_STORE_CLK   12'h008
`define CIT_MRM_STORE_RD    12'h002

// ****************************************
// jumps and address forms, register-indirect and indexed
// ****************************************
`define CIT_JMP_IND_CLK     12'h008
`define CIT_JMP_IND_RD      12'h002
`define CIT_JMP_IDX_CLK     12'h00e
`define CIT_JMP_IDX_RD      12'h003
`define CIT_CALL_IND_CLK    12'h010
`define CIT_CALL_IDX_CLK    12'h016
`define CIT_CALL_RD         12'h002
`define CIT_CALL_WR         12'h002
`define CIT_LEA_IND_CLK     12'h004
`define CIT_LEA_IND_RD      12'h001
`define CIT_LEA_IDX_CLK     12'h00c
`define CIT_LEA_IDX_RD      12'h002
`define CIT_PEA_IND_CLK     12'h00c
`define CIT_PEA_IND_RD      12'h001
`define CIT_PEA_IDX_CLK     12'h014
`define CIT_PEA_IDX_RD      12'h002
`define CIT_PEA_WR          12'h002

// ****************************************
// multiprecision
// ****************************************
`define CIT_XARITH_REG_CLK  12'h004
`define CIT_XARITH_REGL_CLK 12'h008
`define CIT_XARITH_MEM_CLK  12'h012
`define CIT_XARITH_MEML_CLK 12'h01e
`define CIT_DEC_REG_CLK     12'h006
`define CIT_DEC_MEM_CLK     12'h012
`define CIT_MP_REG_RD       12'h001
`define CIT_MP_MEM_RD       12'h003
`define CIT_MP_MEM_WR       12'h001
`define CIT_MP_MEML_RD      12'h005
`define CIT_MP_MEML_WR      12'h002

// ****************************************
// miscellaneous and exceptions
// ****************************************
`define CIT_EXT_RESET_CLK   12'h084
`define CIT_EXT_RESET_RD    12'h001
`define CIT_CHK_PASS_CLK    12'h00a
`define CIT_CHK_PASS_RD     12'h001
`define CIT_CHK_TRAP_CLK    12'h028
`define CIT_DIVZ_CLK        12'h026
`define CIT_EXC_RD          12'h004
`define CIT_EXC_WR          12'h003
`define CIT_BUSERR_CLK      12'h032
`define CIT_BUSERR_WR       12'h007
`define CIT_IRQ_CLK         12'h02c
`define CIT_IRQ_RD          12'h005
`define CIT_TRAP34_CLK      12'h022
`define CIT_OVF_RD          12'h005
`define CIT_RST_SEQ_CLK     12'h028
`define CIT_RST_SEQ_RD      12'h006

`endif
